// ==== logic/sso_status_outputs.v ====
// Summary of operation
// - outputs drive only when assigned to pin
// - torque limit flag, off while servo off
// - zero speed on at or below threshold
// - zero speed off at threshold plus 20
// - hysteresis symmetric in both directions
// - warning output follows any warning
// - warning released within 1.5s of power-on
// - battery warning on codes 92 or 9F
// - battery warning released within 1.5s
// - variable gain output during variable gain
// - position lost output when position erased
// - position lost unavailable in position loop
// - A/B pulses per rev, complementary pairs
// - B lags A by quarter in CCW
// - direction bit inverts phase order
// - one index pulse per revolution
// - index pulse at least 400us wide
`timescale 1ns/1ps
`include "sso_consts.vh"
module sso_status_outputs #(
    parameter [31:0] WARN_HOLD_CYC = `SSO_WARN_HOLD_CYC,
    parameter [31:0] INDEX_MIN_CYC = `SSO_INDEX_MIN_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire irq,
    input wire servo_on,
    input wire torque_at_limit,
    input wire signed [15:0] motor_speed,
    input wire any_warning,
    input wire [7:0] warning_code,
    input wire variable_gain_sel,
    input wire abs_erased,
    input wire enc_step,
    input wire enc_dir_ccw,
    input wire [15:0] monitor_src0,
    input wire [15:0] monitor_src1,
    input wire [15:0] monitor_src2,
    input wire [15:0] monitor_src3,
    output reg [2:0] status_pin,
    output reg enc_phase_a_out,
    output reg enc_phase_a_inverted,
    output reg enc_phase_b_out,
    output reg enc_phase_b_inverted,
    output reg index_pulse_out,
    output reg index_pulse_inverted,
    output reg [9:0] analog_monitor_one,
    output reg [9:0] analog_monitor_two
);

////////////////////////////////////////////////////////////////////////
// registers
reg [1:0] ctrl;
reg [23:0] output_assign_param;
reg [15:0] zero_speed_threshold_param;
reg [15:0] pulses_per_rev_param;
reg [7:0] monitor_sel;
reg [3:0] irq_stat;
reg [3:0] irq_mask;
reg torque_limit_reached;
reg zero_speed_flag;
reg warning_active;
reg battery_warning_active;
reg variable_gain_active;
reg abs_position_lost;
reg [31:0] hold_cnt;
reg [31:0] index_cnt;
reg [15:0] pos_cnt;
reg [1:0] quad;
reg index_evt;

wire phase_direction_param = ctrl[`SSO_CTRL_DIR_INV];
wire pos_loop = ctrl[`SSO_CTRL_POS_LOOP];
wire [3:0] monitor_one_select_param = monitor_sel[3:0];
wire [3:0] monitor_two_select_param = monitor_sel[7:4];
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;
wire hold_done = (hold_cnt >= WARN_HOLD_CYC);

function [15:0] mag;
    input signed [15:0] v;
    begin
        mag = v[15] ? (~v + 16'h0001) : v;
    end
endfunction

function [31:0] merge;
    input [31:0] old;
    input [31:0] nv;
    input [3:0] sel;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = nv[i*8 +: 8];
            end
        end
    end
endfunction

function [9:0] mon_pick;
    input [3:0] s;
    input [15:0] a0;
    input [15:0] a1;
    input [15:0] a2;
    input [15:0] a3;
    begin
        case (s[1:0])
            2'h0: mon_pick = a0[15:6];
            2'h1: mon_pick = a1[15:6];
            2'h2: mon_pick = a2[15:6];
            default: mon_pick = a3[15:6];
        endcase
    end
endfunction

function sel_flag;
    input [3:0] s;
    input [5:0] f;
    begin
        case (s)
            `SSO_SEL_TORQUE: sel_flag = f[0];
            `SSO_SEL_ZERO_SPD: sel_flag = f[1];
            `SSO_SEL_WARN: sel_flag = f[2];
            `SSO_SEL_BWARN: sel_flag = f[3];
            `SSO_SEL_VGAIN: sel_flag = f[4];
            `SSO_SEL_ABSL: sel_flag = f[5];
            default: sel_flag = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// wishbone slave
wire [31:0] wide_ctrl = merge({30'h0, ctrl}, wb_dat_i, wb_sel_i);
wire [31:0] wide_asg = merge({8'h00, output_assign_param}, wb_dat_i, wb_sel_i);
wire [31:0] wide_zs = merge({16'h0000, zero_speed_threshold_param}, wb_dat_i, wb_sel_i);
wire [31:0] wide_ppr = merge({16'h0000, pulses_per_rev_param}, wb_dat_i, wb_sel_i);
wire [31:0] wide_mon = merge({24'h000000, monitor_sel}, wb_dat_i, wb_sel_i);
wire [31:0] wide_msk = merge({28'h0000000, irq_mask}, wb_dat_i, wb_sel_i);
wire stat_rd = wb_req & ~wb_we_i & (wb_adr_i == `SSO_REG_IRQ_STAT);

always @(posedge ref_clk) begin
    if (rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        ctrl <= 2'h0;
        output_assign_param <= `SSO_ASSIGN_RST;
        zero_speed_threshold_param <= `SSO_ZS_THRESH_RST;
        pulses_per_rev_param <= `SSO_PPR_RST;
        monitor_sel <= 8'h10;
        irq_mask <= 4'h0;
    end else begin
        wb_ack_o <= wb_req;
        if (wb_wr) begin
            case (wb_adr_i)
                `SSO_REG_CTRL: ctrl <= wide_ctrl[1:0];
                `SSO_REG_ASSIGN: output_assign_param <= wide_asg[23:0];
                `SSO_REG_ZS_THRESH: zero_speed_threshold_param <= wide_zs[15:0];
                `SSO_REG_PPR: pulses_per_rev_param <= wide_ppr[15:0];
                `SSO_REG_MON_SEL: monitor_sel <= wide_mon[7:0];
                `SSO_REG_IRQ_MASK: irq_mask <= wide_msk[3:0];
                default: ;
            endcase
        end
        if (wb_req & ~wb_we_i) begin
            case (wb_adr_i)
                `SSO_REG_CTRL: wb_dat_o <= {30'h0, ctrl};
                `SSO_REG_ASSIGN: wb_dat_o <= {8'h00, output_assign_param};
                `SSO_REG_ZS_THRESH: wb_dat_o <= {16'h0000, zero_speed_threshold_param};
                `SSO_REG_PPR: wb_dat_o <= {16'h0000, pulses_per_rev_param};
                `SSO_REG_MON_SEL: wb_dat_o <= {24'h000000, monitor_sel};
                `SSO_REG_STATUS: wb_dat_o <= {26'h0, abs_position_lost, variable_gain_active,
                    battery_warning_active, warning_active, zero_speed_flag, torque_limit_reached};
                `SSO_REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
                `SSO_REG_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
                `SSO_REG_WARN_CODE: wb_dat_o <= {24'h000000, warning_code};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// status flags
always @(posedge ref_clk) begin
    if (rst) begin
        hold_cnt <= 32'h00000000;
    end else if (!hold_done) begin
        hold_cnt <= hold_cnt + 32'h00000001;
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        torque_limit_reached <= 1'b0;
        zero_speed_flag <= 1'b0;
        warning_active <= 1'b0;
        battery_warning_active <= 1'b0;
        variable_gain_active <= 1'b0;
        abs_position_lost <= 1'b0;
    end else begin
        torque_limit_reached <= servo_on & torque_at_limit;
        if (mag(motor_speed) <= zero_speed_threshold_param) begin
            zero_speed_flag <= 1'b1;
        end else if (mag(motor_speed) >= zero_speed_threshold_param + `SSO_ZS_HYST) begin
            zero_speed_flag <= 1'b0;
        end
        warning_active <= any_warning | ~hold_done;
        battery_warning_active <= ~hold_done | (any_warning &
            (warning_code == `SSO_WCODE_BATT_CABLE || warning_code == `SSO_WCODE_BATT));
        variable_gain_active <= variable_gain_sel;
        abs_position_lost <= abs_erased & ~pos_loop;
    end
end

////////////////////////////////////////////////////////////////////////
// pin assignment
wire [5:0] flags = {abs_position_lost, variable_gain_active, battery_warning_active,
    warning_active, zero_speed_flag, torque_limit_reached};
integer p;

always @(posedge ref_clk) begin
    if (rst) begin
        status_pin <= 3'h0;
    end else begin
        for (p = 0; p < 3; p = p + 1) begin
            status_pin[p] <= sel_flag(output_assign_param[p*8 +: 4], flags);
        end
    end
end

////////////////////////////////////////////////////////////////////////
// encoder emulation
wire fwd = enc_dir_ccw ^ phase_direction_param;
wire at_top = (pos_cnt == pulses_per_rev_param * 16'h0004 - 16'h0001);
wire [1:0] next_quad = fwd ? quad + 2'h1 : quad - 2'h1;
wire wrap = enc_step & (fwd ? at_top : (pos_cnt == 16'h0000));

always @(posedge ref_clk) begin
    if (rst) begin
        quad <= 2'h0;
        pos_cnt <= 16'h0000;
        index_cnt <= 32'h00000000;
        index_evt <= 1'b0;
        enc_phase_a_out <= 1'b0;
        enc_phase_a_inverted <= 1'b1;
        enc_phase_b_out <= 1'b0;
        enc_phase_b_inverted <= 1'b1;
        index_pulse_out <= 1'b0;
        index_pulse_inverted <= 1'b1;
    end else begin
        index_evt <= wrap;
        // four edges per line, modulo per rev
        if (enc_step) begin
            quad <= next_quad;
            if (fwd) begin
                pos_cnt <= at_top ? 16'h0000 : pos_cnt + 16'h0001;
            end else begin
                pos_cnt <= (pos_cnt == 16'h0000) ? pulses_per_rev_param * 16'h0004 - 16'h0001
                    : pos_cnt - 16'h0001;
            end
        end
        // gray sequence, b lags a forward
        enc_phase_a_out <= quad[1] ^ quad[0];
        enc_phase_a_inverted <= ~(quad[1] ^ quad[0]);
        enc_phase_b_out <= quad[1];
        enc_phase_b_inverted <= ~quad[1];
        if (wrap) begin
            index_cnt <= INDEX_MIN_CYC;
        end else if (index_cnt != 32'h00000000) begin
            index_cnt <= index_cnt - 32'h00000001;
        end
        index_pulse_out <= wrap | (index_cnt > 32'h00000001);
        index_pulse_inverted <= ~(wrap | (index_cnt > 32'h00000001));
    end
end

////////////////////////////////////////////////////////////////////////
// analog monitors and interrupt
always @(posedge ref_clk) begin
    if (rst) begin
        analog_monitor_one <= 10'h000;
        analog_monitor_two <= 10'h000;
        irq_stat <= 4'h0;
    end else begin
        analog_monitor_one <= mon_pick(monitor_one_select_param, monitor_src0, monitor_src1,
            monitor_src2, monitor_src3);
        analog_monitor_two <= mon_pick(monitor_two_select_param, monitor_src0, monitor_src1,
            monitor_src2, monitor_src3);
        // set wins over read clear
        irq_stat <= (stat_rd ? 4'h0 : irq_stat) |
            {index_evt, abs_position_lost, battery_warning_active & hold_done, warning_active & hold_done};
    end
end

assign irq = |(irq_stat & irq_mask);

endmodule // sso_status_outputs

// ==== logic/sso_consts.vh ====
`ifndef SSO_CONSTS_VH
`define SSO_CONSTS_VH
// register byte offsets
`define SSO_REG_CTRL 8'h00
`define SSO_REG_ASSIGN 8'h04
`define SSO_REG_ZS_THRESH 8'h08
`define SSO_REG_PPR 8'h0C
`define SSO_REG_MON_SEL 8'h10
`define SSO_REG_STATUS 8'h14
`define SSO_REG_IRQ_STAT 8'h18
`define SSO_REG_IRQ_MASK 8'h1C
`define SSO_REG_WARN_CODE 8'h20
// ctrl bits
`define SSO_CTRL_DIR_INV 0
`define SSO_CTRL_POS_LOOP 1
// reset values and zero speed hysteresis
`define SSO_ZS_THRESH_RST 16'h0032
`define SSO_ZS_HYST 16'h0014
`define SSO_PPR_RST 16'h1000
`define SSO_ASSIGN_RST 24'h000000
// warning codes
`define SSO_WCODE_BATT_CABLE 8'h92
`define SSO_WCODE_BATT 8'h9F
// output selector codes, 0 = unassigned
`define SSO_SEL_NONE 4'h0
`define SSO_SEL_TORQUE 4'h1
`define SSO_SEL_ZERO_SPD 4'h2
`define SSO_SEL_WARN 4'h3
`define SSO_SEL_BWARN 4'h4
`define SSO_SEL_VGAIN 4'h5
`define SSO_SEL_ABSL 4'h6
// timing
`define SSO_CLK_HZ 50000000
`define SSO_WARN_HOLD_MS 1500
`define SSO_WARN_HOLD_CYC (`SSO_CLK_HZ / 1000 * `SSO_WARN_HOLD_MS)
`define SSO_INDEX_MIN_US 400
`define SSO_INDEX_MIN_CYC (`SSO_CLK_HZ / 1000000 * `SSO_INDEX_MIN_US)
// irq status bits
`define SSO_IRQ_WARN 0
`define SSO_IRQ_BWARN 1
`define SSO_IRQ_ABSL 2
`define SSO_IRQ_INDEX 3
`endif

// ==== dv/sso_status_outputs_asserts.sv ====
`timescale 1ns/1ps
module sso_chk #(
    parameter [31:0] INDEX_MIN_CYC = 32'h8
) (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [2:0] status_pin,
    input wire enc_step,
    input wire enc_phase_a_out,
    input wire enc_phase_a_inverted,
    input wire enc_phase_b_out,
    input wire enc_phase_b_inverted,
    input wire index_pulse_out,
    input wire index_pulse_inverted
);
    logic [31:0] hi_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // length of the running index pulse
    always @(posedge ref_clk) begin
        if (rst || !index_pulse_out)
            hi_cnt <= 32'h0;
        else
            hi_cnt <= hi_cnt + 32'h1;
    end
    property p_a_pair; enc_phase_a_inverted != enc_phase_a_out; endproperty
    a_a_pair: assert property (p_a_pair) else $error("phase a pair equal");
    property p_b_pair; enc_phase_b_inverted != enc_phase_b_out; endproperty
    a_b_pair: assert property (p_b_pair) else $error("phase b pair equal");
    property p_z_pair; index_pulse_inverted != index_pulse_out; endproperty
    a_z_pair: assert property (p_z_pair) else $error("index pair equal");
    property p_quad; !$past(rst) |-> !($changed(enc_phase_a_out) && $changed(enc_phase_b_out)); endproperty
    a_quad: assert property (p_quad) else $error("both phases moved at once");
    property p_cause; (!$past(rst) && $changed({enc_phase_a_out, enc_phase_b_out})) |-> $past(enc_step, 2); endproperty
    a_cause: assert property (p_cause) else $error("phase moved without step");
    property p_width; (!$past(rst) && $fell(index_pulse_out)) |-> hi_cnt >= INDEX_MIN_CYC; endproperty
    a_width: assert property (p_width) else $error("index pulse too short");
    property p_rst; disable iff (1'b0) rst |=> (status_pin == 3'h0 && !wb_ack_o && !index_pulse_out); endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_ack_take; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_take: assert property (p_ack_take) else $error("request not answered");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule // sso_chk

// ==== dv/sso_far_model.sv ====
`timescale 1ns/1ps
module sso_far_model (
    input wire ref_clk,
    input wire rst,
    input wire a,
    input wire b,
    input wire z,
    output logic signed [31:0] pos,
    output logic [15:0] idx_cnt
);
    logic [1:0] prev;
    logic z_q;
    wire [1:0] st = {b, a ^ b};
    wire [1:0] delta = st - prev;
    // pulse counter: up when b lags a
    always @(posedge ref_clk) begin
        prev <= st;
        z_q <= z;
        if (rst) begin
            pos <= 32'sh0;
            idx_cnt <= 16'h0;
        end else begin
            if (delta == 2'h1)
                pos <= pos + 32'sh1;
            else if (delta == 2'h3)
                pos <= pos - 32'sh1;
            if (z && !z_q)
                idx_cnt <= idx_cnt + 16'h1;
        end
    end
endmodule // sso_far_model

// ==== dv/sso_status_outputs_tb.sv ====
`timescale 1ns/1ps
module sso_status_outputs_tb;
    logic ref_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, warning_code = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic servo_on = 1'b1, torque_at_limit = 1'b1, any_warning = 1'b0, variable_gain_sel = 1'b0;
    logic abs_erased = 1'b0, enc_step = 1'b0, enc_dir_ccw = 1'b1;
    logic signed [15:0] motor_speed = 16'h0064;
    logic [15:0] monitor_src0 = 16'h1240, monitor_src1 = 16'h5680, monitor_src2 = 16'h9AC0, monitor_src3 = 16'hFFC0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, irq, enc_phase_a_out, enc_phase_a_inverted, enc_phase_b_out, enc_phase_b_inverted;
    wire index_pulse_out, index_pulse_inverted;
    wire [2:0] status_pin;
    wire [9:0] analog_monitor_one, analog_monitor_two;
    wire signed [31:0] far_pos;
    wire [15:0] far_idx;
    int err_count = 0, n_tests = 0, cyc_n = 0;
    // signed speeds: 0 69 70 60 -50 -69 -70 20 10 29 -30
    logic [15:0] spd [11] = '{16'h0, 16'h45, 16'h46, 16'h3C, 16'hFFCE, 16'hFFBB, 16'hFFBA,
        16'h14, 16'hA, 16'h1D, 16'hFFE2};
    logic [10:0] zs_exp = 11'h333;
    logic [7:0] codes [4] = '{8'h92, 8'h9F, 8'h50, 8'h92};
    sso_status_outputs #(.WARN_HOLD_CYC(32'h32), .INDEX_MIN_CYC(32'h8)) dut (.ref_clk, .rst, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .servo_on,
        .torque_at_limit, .motor_speed, .any_warning, .warning_code, .variable_gain_sel, .abs_erased,
        .enc_step, .enc_dir_ccw, .monitor_src0, .monitor_src1, .monitor_src2, .monitor_src3, .status_pin,
        .enc_phase_a_out, .enc_phase_a_inverted, .enc_phase_b_out, .enc_phase_b_inverted, .index_pulse_out,
        .index_pulse_inverted, .analog_monitor_one, .analog_monitor_two);
    sso_far_model far (.ref_clk, .rst, .a(enc_phase_a_out), .b(enc_phase_b_out), .z(index_pulse_out),
        .pos(far_pos), .idx_cnt(far_idx));
    initial forever #10 ref_clk = ~ref_clk;
    task print_verdict;
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end
    task tk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(wb_dat_o, exp);
    endtask
    task pin(input logic [2:0] e);
        tk(3);
        chk({29'h0, status_pin}, {29'h0, e});
    endtask
    task stp(input int n);
        repeat (n) begin
            enc_step <= 1'b1;
            tk(1);
            enc_step <= 1'b0;
            tk(2);
        end
        // far counter updates one edge after the last pin change
        tk(1);
    endtask
    task mon(input logic [31:0] e);
        tk(3);
        chk({12'h000, analog_monitor_two, analog_monitor_one}, e);
    endtask
    initial begin
        tk(6);
        rst <= 1'b0;
        pin(3'h0);
        rd(8'h08, 32'h32);
        rd(8'h0C, 32'h1000);
        rd(8'h10, 32'h10);
        rd(8'h3C, 32'h0);
        wr(8'h04, 32'h030201);
        pin(3'h5);
        tk(50);
        pin(3'h1);
        servo_on <= 1'b0;
        pin(3'h0);
        any_warning <= 1'b1;
        pin(3'h4);
        any_warning <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            if (i == 7)
                wr(8'h08, 32'hA);
            motor_speed <= spd[i];
            pin({1'b0, zs_exp[i], 1'b0});
        end
        wr(8'h04, 32'h060504);
        for (int i = 0; i < 4; i++) begin
            any_warning <= (i < 3);
            warning_code <= codes[i];
            pin({2'h0, i < 2});
        end
        variable_gain_sel <= 1'b1;
        abs_erased <= 1'b1;
        pin(3'h6);
        wr(8'h00, 32'h2);
        pin(3'h2);
        abs_erased <= 1'b0;
        wr(8'h00, 32'h0);
        mon(32'h00056849);
        wr(8'h10, 32'h23);
        mon(32'h0009AFFF);
        wr(8'h0C, 32'h4);
        stp(20);
        chk(far_pos, 32'h14);
        chk({16'h0, far_idx}, 32'h1);
        wr(8'h00, 32'h1);
        stp(3);
        chk(far_pos, 32'h11);
        chk({16'h0, far_idx}, 32'h1);
        warning_code <= 8'h9F;
        any_warning <= 1'b1;
        tk(4);
        chk({31'h0, irq}, 32'h0);
        rd(8'h14, 32'h1C);
        rd(8'h20, 32'h9F);
        wr(8'h1C, 32'h1);
        tk(2);
        chk({31'h0, irq}, 32'h1);
        any_warning <= 1'b0;
        tk(3);
        rd(8'h18, 32'hF);
        rd(8'h18, 32'h0);
        tk(1);
        chk({31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule // sso_status_outputs_tb
bind sso_status_outputs sso_chk #(.INDEX_MIN_CYC(INDEX_MIN_CYC)) u_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .status_pin, .enc_step, .enc_phase_a_out, .enc_phase_a_inverted, .enc_phase_b_out,
    .enc_phase_b_inverted, .index_pulse_out, .index_pulse_inverted);
